// ### rtl/temp_sense_test_reset_regs.sv
// Purpose: temperature measurement control, tuning test registers and reset sequencing
// Assumes: registers are reached over the serial register bus on its own clock
// Notes:   register reads come from a snapshot frozen while the select line is low
`timescale 1ns/1ns
// What this block does
// - writing one to the trigger bit starts a measurement; the bit reads zero
// - active flag stays one for the whole measurement, then clears
// - eight-bit read-only reading, one code step is minus one degree
// - lna gain register resets to 0x1B normal, 0x2D gives high sensitivity
// - tune A resets to 0x55; 0x5D selects the plus twenty dBm boost point
// - tune B resets to 0x70; 0x7C selects the plus twenty dBm boost point
// - fading margin 0x00 normal, 0x20 or 0x30 improved per narrow index
// - with narrow index enabled, offset equals register times 488 Hz
// - reset at power on and whenever the reset pin is driven
// - reference clock output shows activity once the device is ready
module temp_sense_test_reset_regs
	import temp_test_pkg::*;
#(
	parameter int READY_CYCLES = temp_test_pkg::READY_CYCLES,
	parameter int MEAS_CYCLES  = temp_test_pkg::MEAS_CYCLES
)
(
	// core clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               resetPin,
	// serial register bus
	input  wire logic               sck,
	input  wire logic               nssN,
	input  wire logic               mosi,
	output logic                    miso,
	output logic                    misoOe,
	// sensor and radio side
	input  wire logic [7:0]         tempCode,
	input  wire logic               narrowIndexAfcEnable,
	output logic                    tempMeasureActive,
	output logic [7:0]              lnaGainSelect,
	output logic                    highSensitivity,
	output logic [7:0]              highPowerTuneA,
	output logic [7:0]              highPowerTuneB,
	output logic                    boostHighPower,
	output logic [7:0]              fadingMarginSelect,
	output logic                    marginImproved,
	output logic signed [16:0]      freqOffsetHz,
	// readiness
	output logic                    deviceReady,
	output logic                    refClockOut
);

	spi_reg_if bus ();

	logic        resetPinMeta;
	logic        resetPinSync;
	logic        nssMeta;
	logic        nssSync;
	logic        wrMeta;
	logic        wrSync;
	logic        wrSeen;
	logic        devReset;
	logic        wrStrobe;

	logic [20:0] readyCnt;
	logic [20:0] next_readyCnt;
	logic        next_deviceReady;
	logic [1:0]  refDiv;
	logic [1:0]  next_refDiv;
	logic        next_refClockOut;

	meas_state_e state;
	meas_state_e next_state;
	logic [20:0] measCnt;
	logic [20:0] next_measCnt;
	logic        next_tempMeasureActive;
	logic [7:0]  tempReading;
	logic [7:0]  next_tempReading;
	logic [7:0]  next_lnaGainSelect;
	logic [7:0]  next_highPowerTuneA;
	logic [7:0]  next_highPowerTuneB;
	logic [7:0]  next_fadingMarginSelect;
	logic [7:0]  afcOffset;
	logic [7:0]  next_afcOffset;
	logic        startMeas;

	logic        next_highSensitivity;
	logic        next_boostHighPower;
	logic        next_marginImproved;
	logic signed [16:0] next_freqOffsetHz;

	// ------------------------------------------------------------
	// link end on the bus clock
	// ------------------------------------------------------------
	spi_link_slave linkEnd
	(
		.sck  (sck),
		.nssN (nssN),
		.mosi (mosi),
		.miso (miso),
		.bus  (bus.link)
	);

	// ------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			resetPinMeta <= 1'b0;
			resetPinSync <= 1'b0;
			nssMeta      <= 1'b1;
			nssSync      <= 1'b1;
			wrMeta       <= 1'b0;
			wrSync       <= 1'b0;
			wrSeen       <= 1'b0;
		end
		else
		begin
			resetPinMeta <= resetPin;
			resetPinSync <= resetPinMeta;
			nssMeta      <= nssN;
			nssSync      <= nssMeta;
			wrMeta       <= bus.wrValid;
			wrSync       <= wrMeta;
			wrSeen       <= wrSync;
		end
	end

	// power-on reset and the pin both hold the core in reset
	assign devReset = rst | resetPinSync;
	// write fields are held by the link end while its valid level stands
	assign wrStrobe = wrSync & ~wrSeen;

	// ------------------------------------------------------------
	// readiness and reference clock
	// ------------------------------------------------------------
	always_comb
	begin
		next_readyCnt    = readyCnt;
		next_deviceReady = deviceReady;
		next_refDiv      = refDiv;
		next_refClockOut = refClockOut;
		if (!deviceReady)
		begin
			if (readyCnt == 21'(READY_CYCLES - 1))
				next_deviceReady = 1'b1;
			else
				next_readyCnt = readyCnt + 21'h00_0001;
		end
		else
		begin
			// output stays still until ready, so activity marks readiness
			if (refDiv == 2'(REFCLK_HALF - 1))
			begin
				next_refDiv      = 2'h0;
				next_refClockOut = ~refClockOut;
			end
			else
				next_refDiv = refDiv + 2'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (devReset)
		begin
			readyCnt    <= 21'h00_0000;
			deviceReady <= 1'b0;
			refDiv      <= 2'h0;
			refClockOut <= 1'b0;
		end
		else
		begin
			readyCnt    <= next_readyCnt;
			deviceReady <= next_deviceReady;
			refDiv      <= next_refDiv;
			refClockOut <= next_refClockOut;
		end
	end

	// ------------------------------------------------------------
	// register writes and temperature measurement
	// ------------------------------------------------------------
	always_comb
	begin
		next_lnaGainSelect      = lnaGainSelect;
		next_highPowerTuneA     = highPowerTuneA;
		next_highPowerTuneB     = highPowerTuneB;
		next_fadingMarginSelect = fadingMarginSelect;
		next_afcOffset          = afcOffset;
		startMeas               = 1'b0;
		if (wrStrobe)
		begin
			unique case (bus.wrAddr)
				// trigger is acted on, never stored
				ADDR_TEMP_CTL: startMeas               = bus.wrData[TRIG_BIT];
				ADDR_LNA:      next_lnaGainSelect      = bus.wrData;
				ADDR_PA_ONE:   next_highPowerTuneA     = bus.wrData;
				ADDR_PA_TWO:   next_highPowerTuneB     = bus.wrData;
				ADDR_DAGC:     next_fadingMarginSelect = bus.wrData;
				ADDR_AFC:      next_afcOffset          = bus.wrData;
				default:       startMeas               = 1'b0;
			endcase
		end
	end

	// a trigger during a running measurement is ignored, not queued
	always_comb
	begin
		next_state             = state;
		next_measCnt           = measCnt;
		next_tempMeasureActive = tempMeasureActive;
		next_tempReading       = tempReading;
		unique case (state)
			MEAS_IDLE:
			begin
				if (startMeas)
				begin
					next_state             = MEAS_RUN;
					next_measCnt           = 21'h00_0000;
					next_tempMeasureActive = 1'b1;
				end
			end
			MEAS_RUN:
			begin
				if (measCnt == 21'(MEAS_CYCLES - 1))
				begin
					next_state             = MEAS_IDLE;
					next_tempMeasureActive = 1'b0;
					next_tempReading       = tempCode;
				end
				else
					next_measCnt = measCnt + 21'h00_0001;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (devReset)
		begin
			lnaGainSelect      <= LNA_RESET;
			highPowerTuneA     <= PA_ONE_RESET;
			highPowerTuneB     <= PA_TWO_RESET;
			fadingMarginSelect <= DAGC_RESET;
			afcOffset          <= AFC_RESET;
			state              <= MEAS_IDLE;
			measCnt            <= 21'h00_0000;
			tempMeasureActive  <= 1'b0;
			tempReading        <= TEMP_RES_RESET;
		end
		else
		begin
			lnaGainSelect      <= next_lnaGainSelect;
			highPowerTuneA     <= next_highPowerTuneA;
			highPowerTuneB     <= next_highPowerTuneB;
			fadingMarginSelect <= next_fadingMarginSelect;
			afcOffset          <= next_afcOffset;
			state              <= next_state;
			measCnt            <= next_measCnt;
			tempMeasureActive  <= next_tempMeasureActive;
			tempReading        <= next_tempReading;
		end
	end

	// ------------------------------------------------------------
	// decoded radio settings
	// ------------------------------------------------------------
	always_comb
	begin
		next_highSensitivity = (lnaGainSelect == LNA_HIGH_SENS);
		// boost point needs both tuning values; a half-set pair stays normal
		next_boostHighPower  = (highPowerTuneA == PA_ONE_BOOST) && (highPowerTuneB == PA_TWO_BOOST);
		next_marginImproved  = (fadingMarginSelect != DAGC_NORMAL);
		if (narrowIndexAfcEnable)
			next_freqOffsetHz = 17'($signed(afcOffset) * AFC_STEP_HZ);
		else
			next_freqOffsetHz = 17'sd0;
	end

	always_ff @(posedge clk)
	begin
		if (devReset)
		begin
			highSensitivity <= 1'b0;
			boostHighPower  <= 1'b0;
			marginImproved  <= 1'b1;
			freqOffsetHz    <= 17'sd0;
			misoOe          <= 1'b0;
		end
		else
		begin
			highSensitivity <= next_highSensitivity;
			boostHighPower  <= next_boostHighPower;
			marginImproved  <= next_marginImproved;
			freqOffsetHz    <= next_freqOffsetHz;
			misoOe          <= ~nssSync;
		end
	end

	// ------------------------------------------------------------
	// read snapshot
	// ------------------------------------------------------------
	// frozen while a frame is open so the bus clock side sees stable words
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			bus.snapTempCtl    <= {5'h00, 1'b0, TEMP_CTL_LOW};
			bus.snapTempResult <= TEMP_RES_RESET;
			bus.snapLna        <= LNA_RESET;
			bus.snapPaOne      <= PA_ONE_RESET;
			bus.snapPaTwo      <= PA_TWO_RESET;
			bus.snapDagc       <= DAGC_RESET;
			bus.snapAfc        <= AFC_RESET;
		end
		else if (nssSync)
		begin
			// trigger position always reads zero
			bus.snapTempCtl    <= {5'h00, tempMeasureActive, TEMP_CTL_LOW};
			bus.snapTempResult <= tempReading;
			bus.snapLna        <= lnaGainSelect;
			bus.snapPaOne      <= highPowerTuneA;
			bus.snapPaTwo      <= highPowerTuneB;
			bus.snapDagc       <= fadingMarginSelect;
			bus.snapAfc        <= afcOffset;
		end
	end

endmodule : temp_sense_test_reset_regs

// ### shared/temp_test_pkg.sv
// Purpose: shared constants for the temperature / test-register / reset block
// Assumes: 250 MHz core clock, serial register bus with 7-bit addresses
// Notes:   times are kept in their own unit and turned into cycle counts here
package temp_test_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ       = 250;
	localparam int READY_TIME_US = 5000;
	localparam int READY_CYCLES  = READY_TIME_US * CLK_MHZ;
	localparam int MEAS_TIME_US  = 100;
	localparam int MEAS_CYCLES   = MEAS_TIME_US * CLK_MHZ;
	localparam int REFCLK_HALF   = 4;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [6:0] ADDR_TEMP_CTL    = 7'h4E;
	localparam logic [6:0] ADDR_TEMP_RESULT = 7'h4F;
	localparam logic [6:0] ADDR_LNA         = 7'h58;
	localparam logic [6:0] ADDR_PA_ONE      = 7'h5A;
	localparam logic [6:0] ADDR_PA_TWO      = 7'h5C;
	localparam logic [6:0] ADDR_DAGC        = 7'h6F;
	localparam logic [6:0] ADDR_AFC         = 7'h71;

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int         TRIG_BIT        = 3;
	localparam logic [1:0] TEMP_CTL_LOW    = 2'h1;
	localparam logic [7:0] LNA_RESET       = 8'h1B;
	localparam logic [7:0] LNA_HIGH_SENS   = 8'h2D;
	localparam logic [7:0] PA_ONE_RESET    = 8'h55;
	localparam logic [7:0] PA_ONE_BOOST    = 8'h5D;
	localparam logic [7:0] PA_TWO_RESET    = 8'h70;
	localparam logic [7:0] PA_TWO_BOOST    = 8'h7C;
	localparam logic [7:0] DAGC_RESET      = 8'h30;
	localparam logic [7:0] DAGC_NORMAL     = 8'h00;
	localparam logic [7:0] AFC_RESET       = 8'h00;
	localparam logic [7:0] TEMP_RES_RESET  = 8'h00;
	localparam logic signed [16:0] AFC_STEP_HZ = 17'sd488;

	// ------------------------------------------------------------
	// serial frame bit counts
	// ------------------------------------------------------------
	localparam logic [4:0] SPI_ADDR_LAST = 5'h07;
	localparam logic [4:0] SPI_RD_LOAD   = 5'h08;
	localparam logic [4:0] SPI_DATA_LAST = 5'h0F;
	localparam logic [4:0] SPI_CNT_SAT   = 5'h10;

	typedef enum logic [0:0]
	{
		MEAS_IDLE = 1'b0,
		MEAS_RUN  = 1'b1
	} meas_state_e;

endpackage : temp_test_pkg

// ### shared/spi_reg_if.sv
// Purpose: carrier between the serial link end and the register core
// Assumes: write fields are stable while wrValid is high
// Notes:   snapshot fields are frozen by the core while a frame is open
`timescale 1ns/1ns
interface spi_reg_if;
	logic       wrValid;
	logic [6:0] wrAddr;
	logic [7:0] wrData;
	logic [7:0] snapTempCtl;
	logic [7:0] snapTempResult;
	logic [7:0] snapLna;
	logic [7:0] snapPaOne;
	logic [7:0] snapPaTwo;
	logic [7:0] snapDagc;
	logic [7:0] snapAfc;

	modport link
	(
		output wrValid, wrAddr, wrData,
		input  snapTempCtl, snapTempResult, snapLna, snapPaOne, snapPaTwo, snapDagc, snapAfc
	);
	modport core
	(
		input  wrValid, wrAddr, wrData,
		output snapTempCtl, snapTempResult, snapLna, snapPaOne, snapPaTwo, snapDagc, snapAfc
	);
endinterface : spi_reg_if

// ### rtl/spi_link_slave.sv
// Purpose: serial register bus slave running on the bus clock
// Assumes: mode 0, msb first, first byte is write flag plus 7-bit address
// Notes:   one data byte per frame; further bytes are ignored
`timescale 1ns/1ns
module spi_link_slave
	import temp_test_pkg::*;
(
	// serial pins
	input  wire logic sck,
	input  wire logic nssN,
	input  wire logic mosi,
	output logic      miso,
	// core side
	spi_reg_if.link   bus
);

	logic [4:0] bitCnt;
	logic [7:0] shiftIn;
	logic [7:0] addrByte;
	logic [7:0] txShift;
	logic [4:0] next_bitCnt;
	logic [7:0] next_shiftIn;
	logic [7:0] next_addrByte;
	logic       next_wrValid;
	logic [6:0] next_wrAddr;
	logic [7:0] next_wrData;
	logic [7:0] next_txShift;
	logic       next_miso;
	logic [7:0] readByte;

	// ------------------------------------------------------------
	// receive side, rising edge
	// ------------------------------------------------------------
	always_comb
	begin
		next_bitCnt   = (bitCnt == SPI_CNT_SAT) ? bitCnt : bitCnt + 5'h01;
		next_shiftIn  = {shiftIn[6:0], mosi};
		next_addrByte = addrByte;
		next_wrValid  = bus.wrValid;
		next_wrAddr   = bus.wrAddr;
		next_wrData   = bus.wrData;
		if (bitCnt == SPI_ADDR_LAST)
			next_addrByte = next_shiftIn;
		if (bitCnt == SPI_DATA_LAST && addrByte[7])
		begin
			next_wrValid = 1'b1;
			next_wrAddr  = addrByte[6:0];
			next_wrData  = next_shiftIn;
		end
	end

	// frame state is cleared by the select line, the only edge we can count on
	always_ff @(posedge sck or posedge nssN)
	begin
		if (nssN)
		begin
			bitCnt      <= 5'h00;
			bus.wrValid <= 1'b0;
		end
		else
		begin
			bitCnt      <= next_bitCnt;
			bus.wrValid <= next_wrValid;
		end
	end

	always_ff @(posedge sck)
	begin
		shiftIn    <= next_shiftIn;
		addrByte   <= next_addrByte;
		bus.wrAddr <= next_wrAddr;
		bus.wrData <= next_wrData;
	end

	// ------------------------------------------------------------
	// transmit side, falling edge
	// ------------------------------------------------------------
	always_comb
	begin
		unique case (addrByte[6:0])
			ADDR_TEMP_CTL:    readByte = bus.snapTempCtl;
			ADDR_TEMP_RESULT: readByte = bus.snapTempResult;
			ADDR_LNA:         readByte = bus.snapLna;
			ADDR_PA_ONE:      readByte = bus.snapPaOne;
			ADDR_PA_TWO:      readByte = bus.snapPaTwo;
			ADDR_DAGC:        readByte = bus.snapDagc;
			ADDR_AFC:         readByte = bus.snapAfc;
			default:          readByte = 8'h00;
		endcase
		if (bitCnt == SPI_RD_LOAD && !addrByte[7])
		begin
			next_miso    = readByte[7];
			next_txShift = {readByte[6:0], 1'b0};
		end
		else
		begin
			next_miso    = txShift[7];
			next_txShift = {txShift[6:0], 1'b0};
		end
	end

	always_ff @(negedge sck or posedge nssN)
	begin
		if (nssN)
		begin
			miso    <= 1'b0;
			txShift <= 8'h00;
		end
		else
		begin
			miso    <= next_miso;
			txShift <= next_txShift;
		end
	end

endmodule : spi_link_slave

// ### test/spi_host_model.sv
// Purpose: host side of the serial register bus
// Assumes: mode 0, msb first, one address byte and one data byte per frame
// Notes:   serial clock stands low between frames
`timescale 1ns/1ns
module spi_host_model
(
	// serial pins
	output logic      sck,
	output logic      nssN,
	output logic      mosi,
	input  wire logic miso,
	// readiness as seen by the host
	input  wire logic ready
);
	initial
	begin
		sck  = 1'b0;
		nssN = 1'b1;
		mosi = 1'b0;
	end

	// the 5 ns lead-in makes each frame 577 ns, so back-to-back frames move the bus clock edges 1 ns against the core clock
	task automatic xfer(input logic [7:0] b0, input logic [7:0] b1, output logic [7:0] rd);
		logic [15:0] sh;
		int          i;
		sh = {b0, b1};
		rd = 8'h00;
		wait (ready === 1'b1);
		#5 nssN = 1'b0;
		#20;
		for (i = 0; i < 16; i++)
		begin
			mosi = sh[15 - i];
			#8 sck = 1'b1;
			if (i > 7)
				rd = {rd[6:0], miso};
			#16 sck = 1'b0;
			#8;
		end
		nssN = 1'b1;
		// released line must not look like held data
		mosi = ~mosi;
		#40;
	endtask : xfer
endmodule : spi_host_model

// ### test/temp_sense_test_reset_regs_monitor.sv
// Purpose: port assertions for the temperature / test register block
// Assumes: core clock domain only
// Notes:   serial pins are judged by the bench
`timescale 1ns/1ns
module temp_sense_test_reset_regs_monitor
	import temp_test_pkg::*;
#(
	parameter int READY_CYCLES = 50,
	parameter int MEAS_CYCLES  = 20
)
(
	// core
	input wire logic               clk,
	input wire logic               rst,
	input wire logic               resetPin,
	// radio side
	input wire logic               narrowIndexAfcEnable,
	input wire logic               tempMeasureActive,
	input wire logic [7:0]         lnaGainSelect,
	input wire logic               highSensitivity,
	input wire logic [7:0]         highPowerTuneA,
	input wire logic [7:0]         highPowerTuneB,
	input wire logic               boostHighPower,
	input wire logic [7:0]         fadingMarginSelect,
	input wire logic               marginImproved,
	input wire logic signed [16:0] freqOffsetHz,
	// readiness
	input wire logic               deviceReady,
	input wire logic               refClockOut
);
	int activeRun;
	int next_activeRun;

	always_comb next_activeRun = tempMeasureActive ? activeRun + 1 : 0;
	always_ff @(posedge clk) activeRun <= rst ? 0 : next_activeRun;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || resetPin);

	property p_sens; lnaGainSelect == LNA_HIGH_SENS |=> highSensitivity; endproperty
	a_sens: assert property (p_sens) else $error("high sensitivity not set");
	property p_norm; lnaGainSelect == LNA_RESET |=> !highSensitivity; endproperty
	a_norm: assert property (p_norm) else $error("high sensitivity in normal mode");
	property p_boost; highPowerTuneA == PA_ONE_BOOST && highPowerTuneB == PA_TWO_BOOST |=> boostHighPower; endproperty
	a_boost: assert property (p_boost) else $error("boost point not selected");
	property p_no_boost; highPowerTuneA == PA_ONE_RESET || highPowerTuneB == PA_TWO_RESET |=> !boostHighPower; endproperty
	a_no_boost: assert property (p_no_boost) else $error("boost point with normal tuning");
	property p_margin; fadingMarginSelect == DAGC_NORMAL |=> !marginImproved; endproperty
	a_margin: assert property (p_margin) else $error("margin improved in normal mode");
	property p_off_zero; !narrowIndexAfcEnable |=> freqOffsetHz == 0; endproperty
	a_off_zero: assert property (p_off_zero) else $error("offset while disabled");
	property p_off_step; narrowIndexAfcEnable |=> freqOffsetHz % 488 == 0; endproperty
	a_off_step: assert property (p_off_step) else $error("offset not a step multiple");
	property p_rst;
		disable iff (1'b0)
		rst |=> lnaGainSelect == LNA_RESET && highPowerTuneA == PA_ONE_RESET && highPowerTuneB == PA_TWO_RESET
			&& fadingMarginSelect == DAGC_RESET && !tempMeasureActive && !deviceReady && !refClockOut;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	property p_meas_len; $fell(tempMeasureActive) && !$past(rst) |-> activeRun == MEAS_CYCLES; endproperty
	a_meas_len: assert property (p_meas_len) else $error("measurement length wrong");
	property p_ready_clk; !deviceReady |-> !refClockOut; endproperty
	a_ready_clk: assert property (p_ready_clk) else $error("reference clock before ready");
	property p_clk_start; $rose(deviceReady) |-> ##[1:8] refClockOut; endproperty
	a_clk_start: assert property (p_clk_start) else $error("reference clock idle after ready");
endmodule : temp_sense_test_reset_regs_monitor

bind temp_sense_test_reset_regs temp_sense_test_reset_regs_monitor #(
	.READY_CYCLES(READY_CYCLES),
	.MEAS_CYCLES(MEAS_CYCLES)
) mon_i (
	.clk(clk), .rst(rst), .resetPin(resetPin), .narrowIndexAfcEnable(narrowIndexAfcEnable),
	.tempMeasureActive(tempMeasureActive), .lnaGainSelect(lnaGainSelect), .highSensitivity(highSensitivity),
	.highPowerTuneA(highPowerTuneA), .highPowerTuneB(highPowerTuneB), .boostHighPower(boostHighPower),
	.fadingMarginSelect(fadingMarginSelect), .marginImproved(marginImproved), .freqOffsetHz(freqOffsetHz),
	.deviceReady(deviceReady), .refClockOut(refClockOut)
);

// ### test/tb_temp_sense_test_reset_regs.sv
// Purpose: self-checking bench for the temperature / test register block
// Assumes: shortened ready and measurement counts
// Notes:   all register traffic goes through the host model
`timescale 1ns/1ns
module tb_temp_sense_test_reset_regs;
	import temp_test_pkg::*;
	localparam int RDY  = 50;
	localparam int MEAS = 800;
	logic                    clk, rst, resetPin, narrowIndexAfcEnable;
	logic [7:0]              tempCode;
	wire logic               sck, nssN, mosi, miso, misoOe, tempMeasureActive, highSensitivity;
	wire logic               boostHighPower, marginImproved, deviceReady, refClockOut;
	wire logic [7:0]         lnaGainSelect, highPowerTuneA, highPowerTuneB, fadingMarginSelect;
	wire logic signed [16:0] freqOffsetHz;
	int                      errTotal, samplesChecked;

	temp_sense_test_reset_regs #(.READY_CYCLES(RDY), .MEAS_CYCLES(MEAS)) temp_sense_test_reset_regs_i (
		.clk, .rst, .resetPin, .sck, .nssN, .mosi, .miso, .misoOe, .tempCode, .narrowIndexAfcEnable,
		.tempMeasureActive, .lnaGainSelect, .highSensitivity, .highPowerTuneA, .highPowerTuneB,
		.boostHighPower, .fadingMarginSelect, .marginImproved, .freqOffsetHz, .deviceReady, .refClockOut);
	spi_host_model spi_host_model_i (.sck, .nssN, .mosi, .miso, .ready(deviceReady));

	// ----
	// helpers
	// ----
	task chk(input logic [16:0] got, input logic [16:0] exp);
		samplesChecked++;
		if (got !== exp)
		begin
			errTotal++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] x;
		spi_host_model_i.xfer({1'b1, a}, d, x);
	endtask : wr
	task rdchk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		spi_host_model_i.xfer({1'b0, a}, 8'h00, d);
		chk(d, e);
	endtask : rdchk
	task endSim;
		$display("checks %0d errors %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : endSim

	// ----
	// scenarios
	// ----
	task t_ready;
		int n;
		n = 0;
		while (deviceReady !== 1'b1 && n < 1000)
		begin
			tick(1);
			n++;
		end
		chk(17'(n), 17'(RDY));
		tick(3);
		chk(refClockOut, 1'b0);
		tick(1);
		chk(refClockOut, 1'b1);
		$display("done: ready");
	endtask : t_ready
	task t_defaults;
		logic [6:0] a [8];
		logic [7:0] e [8];
		a = '{ADDR_TEMP_CTL, ADDR_TEMP_RESULT, ADDR_LNA, ADDR_PA_ONE, ADDR_PA_TWO, ADDR_DAGC, ADDR_AFC, 7'h50};
		e = '{8'h01, TEMP_RES_RESET, LNA_RESET, PA_ONE_RESET, PA_TWO_RESET, DAGC_RESET, AFC_RESET, 8'h00};
		chk(misoOe, 1'b0);
		// read-only, trigger-less and unmapped writes must change nothing
		wr(ADDR_TEMP_RESULT, 8'hA5);
		wr(ADDR_TEMP_CTL, 8'hF7);
		wr(7'h50, 8'hFF);
		for (int i = 0; i < 8; i++)
			rdchk(a[i], e[i]);
		$display("done: defaults");
	endtask : t_defaults
	task t_tune;
		wr(ADDR_LNA, LNA_HIGH_SENS);
		wr(ADDR_PA_ONE, PA_ONE_BOOST);
		wr(ADDR_PA_TWO, PA_TWO_BOOST);
		wr(ADDR_DAGC, DAGC_NORMAL);
		wr(ADDR_AFC, 8'hFF);
		@(posedge clk) narrowIndexAfcEnable <= 1'b1;
		tick(3);
		chk(highSensitivity, 1'b1);
		chk(highPowerTuneA, PA_ONE_BOOST);
		chk(highPowerTuneB, PA_TWO_BOOST);
		chk(fadingMarginSelect, DAGC_NORMAL);
		chk(boostHighPower, 1'b1);
		chk(marginImproved, 1'b0);
		chk(freqOffsetHz, -17'sd488);
		rdchk(ADDR_AFC, 8'hFF);
		wr(ADDR_DAGC, 8'h20);
		wr(ADDR_PA_TWO, PA_TWO_RESET);
		tick(3);
		chk(boostHighPower, 1'b0);
		wr(ADDR_PA_ONE, PA_ONE_RESET);
		wr(ADDR_LNA, LNA_RESET);
		@(posedge clk) narrowIndexAfcEnable <= 1'b0;
		tick(3);
		chk(marginImproved, 1'b1);
		chk(highSensitivity, 1'b0);
		chk(freqOffsetHz, 17'h0_0000);
		$display("done: tuning");
	endtask : t_tune
	task t_temp;
		int n;
		@(posedge clk) tempCode <= 8'hC3;
		wr(ADDR_TEMP_CTL, 8'h08);
		chk(tempMeasureActive, 1'b1);
		rdchk(ADDR_TEMP_CTL, 8'h05);
		// a second trigger mid-run must not stretch the run
		wr(ADDR_TEMP_CTL, 8'h08);
		n = 0;
		while (tempMeasureActive !== 1'b0 && n < 2000)
		begin
			tick(1);
			n++;
		end
		chk(tempMeasureActive, 1'b0);
		@(posedge clk) tempCode <= 8'h11;
		rdchk(ADDR_TEMP_RESULT, 8'hC3);
		rdchk(ADDR_TEMP_CTL, 8'h01);
		$display("done: temperature");
	endtask : t_temp
	task t_reset;
		wr(ADDR_LNA, LNA_HIGH_SENS);
		@(posedge clk) resetPin <= 1'b1;
		tick(25);
		chk(deviceReady, 1'b0);
		chk(lnaGainSelect, LNA_RESET);
		@(posedge clk) resetPin <= 1'b0;
		rdchk(ADDR_LNA, LNA_RESET);
		$display("done: manual reset");
	endtask : t_reset

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		#100000;
		errTotal++;
		$display("ERROR %0t: timeout", $time);
		endSim();
	end
	initial
	begin
		rst = 1'b1;
		resetPin = 1'b0;
		tempCode = 8'h00;
		narrowIndexAfcEnable = 1'b0;
		errTotal = 0;
		samplesChecked = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_ready();
		t_defaults();
		t_tune();
		t_temp();
		t_reset();
		endSim();
	end
endmodule : tb_temp_sense_test_reset_regs
